//--- pscsr_pkg.sv
// Constants of the proximity sensor configuration and status register bank.
// Assumes one 100 MHz clock; offsets are the 5-bit register pointer values.
//
// What this block does
// - Wait-stretch flag set makes every wait interval twelve times the wait count.
// - Wait steps are 2.72 ms per count; count is two's complement.
// - Each measurement emits the programmed emitter pulse total at 62.5 kHz.
// - LED drive bits 7:6 give full, half, quarter or eighth current.
// - Eight-bit read-only part identifier returns a fixed variant code.
// - Read-only status register sits at offset 0x13, showing internal state.
// - Status bit 5 is set while a proximity interrupt stays pending.
// - Result below low threshold or above high threshold raises an interrupt.
// - Sixteen-bit result: low byte at 0x18, high byte at 0x19.
// - Reading the low byte copies the high byte into a shadow.
// - High-byte read returns the byte paired with the earlier low read.

`default_nettype none

package pscsr_pkg;

   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [4:0] OFF_WAIT_EXT = 5'h0d;
   localparam logic [4:0] OFF_PULSE = 5'h0e;
   localparam logic [4:0] OFF_SETUP = 5'h0f;
   localparam logic [4:0] OFF_PART_ID = 5'h12;
   localparam logic [4:0] OFF_FLAGS = 5'h13;
   localparam logic [4:0] OFF_RES_LO = 5'h18;
   localparam logic [4:0] OFF_RES_HI = 5'h19;

   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int STRETCH_BIT = 1;
   localparam int DRIVE_LSB = 6;
   localparam int DIODE_LSB = 4;
   localparam int IRQ_FLAG_BIT = 5;
   localparam int CMD_BIT = 7;
   localparam int CMD_TYPE_LSB = 5;
   localparam logic [1:0] CMD_AUTOINC = 2'h1;
   localparam logic [7:0] RST_WAIT_EXT = 8'h00;
   localparam logic [7:0] RST_PULSE = 8'h00;
   localparam logic [7:0] RST_SETUP = 8'h00;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam real CLK_MHZ = 100.0;
   localparam real WAIT_STEP_MS = 2.72;
   localparam real PULSE_RATE_KHZ = 62.5;
   localparam int WAIT_STRETCH_FACTOR = 12;
   localparam int WAIT_STEP_CYC = int'(WAIT_STEP_MS * 1000.0 * CLK_MHZ);
   localparam int PULSE_CYC = int'(CLK_MHZ * 1000.0 / PULSE_RATE_KHZ);

endpackage : pscsr_pkg

`default_nettype wire

//--- pscsr_emit_if.sv
// Carrier between the register bank and the emitter sequencer.
// Assumes both ends share the bank's clock.

`timescale 1ns/10ps
`default_nettype none

interface pscsr_emit_if;
   logic run;
   logic wait_en;
   logic wait_stretch_flag;
   logic [7:0] wait_count;
   logic [7:0] emitter_pulse_total;
   logic led_pulse;
   logic burst_done;

   modport ctrl (output run, output wait_en, output wait_stretch_flag, output wait_count,
                 output emitter_pulse_total, input led_pulse, input burst_done);
   modport emit (input run, input wait_en, input wait_stretch_flag, input wait_count,
                 input emitter_pulse_total, output led_pulse, output burst_done);
endinterface : pscsr_emit_if

`default_nettype wire

//--- pscsr_emitter.sv
// Emitter sequencer: pulse burst, then programmed wait, repeated while run.
// Assumes settings are static during a burst or wait.

`timescale 1ns/10ps
`default_nettype none

module pscsr_emitter
   import pscsr_pkg::*;
#(
   parameter int STEP_CYC = WAIT_STEP_CYC
) (
   input wire logic mclk_in,
   input wire logic srst_in,
   pscsr_emit_if.emit em
);

   typedef enum logic [2:0] {
      EM_IDLE = 3'b001,
      EM_BURST = 3'b010,
      EM_WAIT = 3'b100
   } pscsr_em_type;

   pscsr_em_type state_ff;
   logic [18:0] cyc_ff;
   logic [8:0] pcnt_ff;
   logic [8:0] steps_ff;
   logic [3:0] sub_ff;
   logic pulse_ff;
   logic done_ff;

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   wire burst_end = (pcnt_ff[7:0] == em.emitter_pulse_total);
   wire pulse_wrap = (cyc_ff == 19'(PULSE_CYC - 1));
   wire step_wrap = (cyc_ff == 19'(STEP_CYC - 1));
   // Twelve sub-steps make one stretched step
   wire sub_last = !em.wait_stretch_flag || (sub_ff == 4'(WAIT_STRETCH_FACTOR - 1));

   // Steps of the wait: 0xff gives 1, 0x00 gives 256
   function automatic logic [8:0] wait_steps(input logic [7:0] cnt);
      wait_steps = 9'h100 - {1'b0, cnt};
   endfunction

   // Sequencer; dropping run aborts at once so the LED never stays lit
   always_ff @(posedge mclk_in) begin
      done_ff <= 1'b0;
      if (srst_in || !em.run) begin
         state_ff <= EM_IDLE;
         cyc_ff <= 19'h0;
         pcnt_ff <= 9'h0;
         steps_ff <= 9'h0;
         sub_ff <= 4'h0;
      end else begin
         case (state_ff)
            EM_IDLE: begin
               state_ff <= EM_BURST;
               cyc_ff <= 19'h0;
               pcnt_ff <= 9'h0;
            end
            EM_BURST: begin
               if (burst_end) begin
                  done_ff <= 1'b1;
                  cyc_ff <= 19'h0;
                  sub_ff <= 4'h0;
                  steps_ff <= wait_steps(em.wait_count);
                  pcnt_ff <= 9'h0;
                  state_ff <= em.wait_en ? EM_WAIT : EM_BURST;
               end else if (pulse_wrap) begin
                  cyc_ff <= 19'h0;
                  pcnt_ff <= pcnt_ff + 9'h1;
               end else begin
                  cyc_ff <= cyc_ff + 19'h1;
               end
            end
            EM_WAIT: begin
               if (!step_wrap) begin
                  cyc_ff <= cyc_ff + 19'h1;
               end else begin
                  cyc_ff <= 19'h0;
                  sub_ff <= sub_last ? 4'h0 : sub_ff + 4'h1;
                  if (sub_last) begin
                     steps_ff <= steps_ff - 9'h1;
                     if (steps_ff == 9'h1) begin
                        state_ff <= EM_BURST;
                     end
                  end
               end
            end
            default: state_ff <= EM_IDLE;
         endcase
      end
   end

   // LED high for the first half of each 16 us pulse period
   always_ff @(posedge mclk_in) begin
      pulse_ff <= !srst_in && em.run && (state_ff == EM_BURST) && !burst_end &&
                  (cyc_ff < 19'(PULSE_CYC / 2));
   end

   assign em.led_pulse = pulse_ff;
   assign em.burst_done = done_ff;

endmodule : pscsr_emitter

`default_nettype wire

//--- pscsr_regs.sv
// Register bank of the proximity sensor on the two-wire serial port.
// Assumes SCL and SDA come from pins; thresholds and results from the sensor core.

`timescale 1ns/10ps
`default_nettype none

module pscsr_regs
   import pscsr_pkg::*;
#(
   parameter int WAIT_STEP_CYC_P = WAIT_STEP_CYC,
   parameter logic [6:0] DEV_ADDR = 7'h2a,  // Arbitrary value
   parameter logic [7:0] PART_ID = 8'h5a    // Arbitrary value
) (
   input wire logic mclk_in,
   input wire logic srst_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   output logic irq_n_out,
   output logic irq_oe_out,
   input wire logic meas_enable_in,
   input wire logic wait_enable_in,
   input wire logic [7:0] wait_count_in,
   input wire logic prox_irq_enable_in,
   input wire logic prox_irq_clear_in,
   input wire logic [15:0] low_thr_in,
   input wire logic [15:0] high_thr_in,
   input wire logic [15:0] result_in,
   input wire logic result_valid_in,
   output logic led_pulse_out,
   output logic burst_done_out,
   output logic [3:0] led_drive_scale_out,
   output logic diode_ch0_en_out,
   output logic diode_ch1_en_out
);

   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_RX = 5'b00010,
      ST_ACK = 5'b00100,
      ST_TX = 5'b01000,
      ST_MACK = 5'b10000
   } pscsr_bus_type;

   // ---------------------------------------------------------------
   // Pin sampling
   // ---------------------------------------------------------------
   logic [1:0] pin_s1_ff;
   logic [1:0] pin_s2_ff;
   logic [1:0] pin_s3_ff;
   logic [1:0] pin_f_ff;
   logic [1:0] pin_p_ff;

   // Three stages; a level counts only once stages two and three agree
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         pin_s1_ff <= 2'h3;
         pin_s2_ff <= 2'h3;
         pin_s3_ff <= 2'h3;
         pin_f_ff <= 2'h3;
         pin_p_ff <= 2'h3;
      end else begin
         pin_s1_ff <= {scl_in, sda_in};
         pin_s2_ff <= pin_s1_ff;
         pin_s3_ff <= pin_s2_ff;
         pin_f_ff[1] <= (pin_s2_ff[1] == pin_s3_ff[1]) ? pin_s3_ff[1] : pin_f_ff[1];
         pin_f_ff[0] <= (pin_s2_ff[0] == pin_s3_ff[0]) ? pin_s3_ff[0] : pin_f_ff[0];
         pin_p_ff <= pin_f_ff;
      end
   end

   // Edge and bus condition decode
   wire scl_f = pin_f_ff[1];
   wire sda_f = pin_f_ff[0];
   wire scl_rise = scl_f && !pin_p_ff[1];
   wire scl_fall = !scl_f && pin_p_ff[1];
   wire scl_high = scl_f && pin_p_ff[1];
   wire bus_start = scl_high && pin_p_ff[0] && !sda_f;
   wire bus_stop = scl_high && !pin_p_ff[0] && sda_f;

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [7:0] wait_ext_ff;
   logic [7:0] pulse_ff;
   logic [7:0] setup_ff;
   logic [15:0] result_ff;
   logic [7:0] shadow_hi_ff;
   logic irq_pend_ff;
   logic [4:0] ptr_ff;
   logic autoinc_ff;

   // ---------------------------------------------------------------
   // Serial port state
   // ---------------------------------------------------------------
   pscsr_bus_type state_ff;
   logic [3:0] bit_cnt_ff;
   logic [7:0] shift_ff;
   logic [1:0] byte_idx_ff;
   logic read_ff;
   logic drv_ff;
   logic [7:0] rd_data;

   wire byte_in = (state_ff == ST_RX) && scl_fall && (bit_cnt_ff == 4'h8);
   wire addr_hit = (shift_ff[7:1] == DEV_ADDR);
   wire cmd_in = byte_in && (byte_idx_ff == 2'h1) && shift_ff[CMD_BIT];
   wire wr_in = byte_in && (byte_idx_ff == 2'h2);
   wire tx_load = scl_fall && (((state_ff == ST_ACK) && read_ff) || (state_ff == ST_MACK));

   // Pointer step after each data byte when auto-increment was asked for
   function automatic logic [4:0] ptr_step(input logic [4:0] p, input logic inc);
      ptr_step = inc ? p + 5'h1 : p;
   endfunction

   // Read data selection; reserved bits read as zero
   always_comb begin
      case (ptr_ff)
         OFF_WAIT_EXT: rd_data = wait_ext_ff;
         OFF_PULSE: rd_data = pulse_ff;
         OFF_SETUP: rd_data = setup_ff;
         OFF_PART_ID: rd_data = PART_ID;
         OFF_FLAGS: rd_data = 8'(irq_pend_ff) << IRQ_FLAG_BIT;
         OFF_RES_LO: rd_data = result_ff[7:0];
         OFF_RES_HI: rd_data = shadow_hi_ff;
         default: rd_data = 8'h00;
      endcase
   end

   // Byte-level sequencer; start and stop override any state
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         state_ff <= ST_IDLE;
         bit_cnt_ff <= 4'h0;
         shift_ff <= 8'h00;
         byte_idx_ff <= 2'h0;
         read_ff <= 1'b0;
         drv_ff <= 1'b0;
      end else if (bus_start) begin
         state_ff <= ST_RX;
         bit_cnt_ff <= 4'h0;
         byte_idx_ff <= 2'h0;
         drv_ff <= 1'b0;
      end else if (bus_stop) begin
         state_ff <= ST_IDLE;
         drv_ff <= 1'b0;
      end else begin
         case (state_ff)
            ST_IDLE: drv_ff <= 1'b0;
            ST_RX: begin
               if (scl_rise) begin
                  shift_ff <= {shift_ff[6:0], sda_f};
                  bit_cnt_ff <= bit_cnt_ff + 4'h1;
               end else if (byte_in) begin
                  bit_cnt_ff <= 4'h0;
                  if (byte_idx_ff != 2'h0 || addr_hit) begin
                     drv_ff <= 1'b1;
                     state_ff <= ST_ACK;
                  end else begin
                     state_ff <= ST_IDLE;
                  end
                  if (byte_idx_ff == 2'h0) begin
                     read_ff <= shift_ff[0];
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  byte_idx_ff <= (byte_idx_ff == 2'h2) ? 2'h2 : byte_idx_ff + 2'h1;
                  bit_cnt_ff <= 4'h0;
                  if (read_ff) begin
                     shift_ff <= rd_data;
                     drv_ff <= !rd_data[7];
                     state_ff <= ST_TX;
                  end else begin
                     drv_ff <= 1'b0;
                     state_ff <= ST_RX;
                  end
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (bit_cnt_ff == 4'h7) begin
                     drv_ff <= 1'b0;
                     state_ff <= ST_MACK;
                  end else begin
                     shift_ff <= {shift_ff[6:0], 1'b0};
                     drv_ff <= !shift_ff[6];
                     bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  end
               end
            end
            ST_MACK: begin
               // A not-acknowledge ends the read; controller sends stop next
               if (scl_rise && sda_f) begin
                  state_ff <= ST_IDLE;
               end else if (scl_fall) begin
                  shift_ff <= rd_data;
                  drv_ff <= !rd_data[7];
                  bit_cnt_ff <= 4'h0;
                  state_ff <= ST_TX;
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // Command byte sets the pointer; with auto-increment, data bytes and reads advance it
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         ptr_ff <= 5'h00;
         autoinc_ff <= 1'b0;
      end else if (cmd_in) begin
         ptr_ff <= shift_ff[4:0];
         autoinc_ff <= (shift_ff[CMD_TYPE_LSB +: 2] == CMD_AUTOINC);
      end else if (wr_in || tx_load) begin
         ptr_ff <= ptr_step(ptr_ff, autoinc_ff);
      end
   end

   // Writable registers keep only their defined bits
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         wait_ext_ff <= RST_WAIT_EXT;
         pulse_ff <= RST_PULSE;
         setup_ff <= RST_SETUP;
      end else if (wr_in) begin
         case (ptr_ff)
            OFF_WAIT_EXT: wait_ext_ff <= shift_ff & (8'h01 << STRETCH_BIT);
            OFF_PULSE: pulse_ff <= shift_ff;
            OFF_SETUP: setup_ff <= {shift_ff[7:4], 4'h0};
            default: pulse_ff <= pulse_ff;
         endcase
      end
   end

   // Result capture and high-byte shadow; the shadow only moves on a low read,
   // so a conversion landing between the two reads cannot split the pair
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         result_ff <= 16'h0000;
         shadow_hi_ff <= 8'h00;
      end else begin
         if (result_valid_in) begin
            result_ff <= result_in;
         end
         if (tx_load && ptr_ff == OFF_RES_LO) begin
            shadow_hi_ff <= result_ff[15:8];
         end
      end
   end

   // ---------------------------------------------------------------
   // Proximity interrupt
   // ---------------------------------------------------------------
   wire out_of_band = (result_in < low_thr_in) || (result_in > high_thr_in);
   wire irq_set = result_valid_in && prox_irq_enable_in && out_of_band;

   // Set wins over a clear in the same cycle so no event is lost
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         irq_pend_ff <= 1'b0;
      end else if (irq_set) begin
         irq_pend_ff <= 1'b1;
      end else if (prox_irq_clear_in) begin
         irq_pend_ff <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Pins and analog controls
   // ---------------------------------------------------------------
   assign sda_out = 1'b0;
   assign sda_oe_out = drv_ff;
   assign irq_n_out = 1'b0;
   assign irq_oe_out = irq_pend_ff; // Open drain, pulled low while pending

   // Drive scale is one-hot: bit 0 full, 1 half, 2 quarter, 3 eighth
   assign led_drive_scale_out = 4'h1 << setup_ff[DRIVE_LSB +: 2];
   assign diode_ch0_en_out = setup_ff[DIODE_LSB];
   assign diode_ch1_en_out = setup_ff[DIODE_LSB + 1];

   // ---------------------------------------------------------------
   // Emitter sequencer
   // ---------------------------------------------------------------
   pscsr_emit_if em_if ();

   assign em_if.run = meas_enable_in;
   assign em_if.wait_en = wait_enable_in;
   assign em_if.wait_stretch_flag = wait_ext_ff[STRETCH_BIT];
   assign em_if.wait_count = wait_count_in;
   assign em_if.emitter_pulse_total = pulse_ff;

   pscsr_emitter #(
      .STEP_CYC(WAIT_STEP_CYC_P)
   ) u_emitter (
      .mclk_in(mclk_in),
      .srst_in(srst_in),
      .em(em_if.emit)
   );

   assign led_pulse_out = em_if.led_pulse;
   assign burst_done_out = em_if.burst_done;

endmodule : pscsr_regs

`default_nettype wire

//--- pscsr_regs_asserts.sv
// Checker on the bank's ports: interrupt, pulses, drive.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module pscsr_regs_asserts (
   input wire logic mclk_in,
   input wire logic srst_in,
   input wire logic meas_enable_in,
   input wire logic prox_irq_enable_in,
   input wire logic prox_irq_clear_in,
   input wire logic [15:0] low_thr_in,
   input wire logic [15:0] high_thr_in,
   input wire logic [15:0] result_in,
   input wire logic result_valid_in,
   input wire logic irq_oe_out,
   input wire logic led_pulse_out,
   input wire logic burst_done_out,
   input wire logic [3:0] led_drive_scale_out
);
   logic led_d_ff;
   logic [10:0] hi_cnt_ff;
   logic [11:0] since_ff;
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (srst_in);
   // ------------------------
   // Helper logic
   // ------------------------
   // Out-of-window result while permitted
   wire logic irq_hit = result_valid_in && prox_irq_enable_in
      && (result_in < low_thr_in || result_in > high_thr_in);
   wire logic led_rise = led_pulse_out && !led_d_ff;
   // High time and rise spacing; spacing saturates
   always_ff @(posedge mclk_in) begin
      led_d_ff <= led_pulse_out && !srst_in;
      hi_cnt_ff <= (srst_in || !led_pulse_out) ? 11'h0 : hi_cnt_ff + 11'h1;
      if (srst_in || (since_ff == 12'hfff && !led_rise)) begin
         since_ff <= 12'hfff;
      end else begin
         since_ff <= led_rise ? 12'h1 : since_ff + 12'h1;
      end
   end
   // ------------------------
   // Assertions
   // ------------------------
   AST_DRIVE_ONEHOT: assert property ($onehot(led_drive_scale_out))
      else $error("drive not one-hot");
   AST_IRQ_SET: assert property (irq_hit |=> irq_oe_out)
      else $error("irq not raised");
   AST_IRQ_HOLD: assert property (irq_oe_out && !prox_irq_clear_in |=> irq_oe_out)
      else $error("irq dropped");
   AST_IRQ_CLEAR: assert property (prox_irq_clear_in && !irq_hit |=> !irq_oe_out)
      else $error("irq not cleared");
   AST_IRQ_NO_CAUSE: assert property (!irq_oe_out && !irq_hit |=> !irq_oe_out)
      else $error("irq without cause");
   AST_PULSE_HIGH: assert property ($fell(led_pulse_out) && meas_enable_in |->
      hi_cnt_ff == 11'd800) else $error("pulse width wrong");
   AST_PULSE_SPACING: assert property (led_rise |-> since_ff >= 12'd1600)
      else $error("pulses too close");
   AST_DONE_ONE_CYCLE: assert property (burst_done_out |=> !burst_done_out)
      else $error("done too long");
   AST_IDLE_DARK: assert property (!meas_enable_in [*2] |-> !led_pulse_out)
      else $error("lit while disabled");
   COV_IRQ: cover property (irq_hit ##1 irq_oe_out);
   COV_BURST: cover property (burst_done_out);
   COV_SPACED_RISE: cover property (led_rise && since_ff == 12'd1600);
endmodule // pscsr_regs_asserts
bind pscsr_regs pscsr_regs_asserts u_chk (.*);
`default_nettype wire

//--- pscsr_host_model.sv
// Host model: bit-banged two-wire controller, 16 clocks per SCL period.
// Assumes the bench resolves SDA with a pull-up.
`timescale 1ns/10ps
`default_nettype none
module pscsr_host_model #(
   parameter logic [6:0] DEV_ADDR = 7'h2a
) (
   input wire logic mclk_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_low_out
);
   // Bus idles released; SCL runs only inside frames
   initial begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_in);
   endtask
   // Data moves while SCL is low, sampled late in the high phase
   task automatic xbit(input logic b, output logic r);
      sda_low_out <= ~b;
      tick(4);
      scl_out <= 1'b1;
      tick(8);
      r = sda_in;
      scl_out <= 1'b0;
      tick(4);
   endtask
   // SDA moves in the high phase: falling is a start, rising a stop
   task automatic cond(input logic a, input logic b);
      sda_low_out <= a;
      tick(4);
      scl_out <= 1'b1;
      tick(8);
      sda_low_out <= b;
      tick(8);
   endtask
   // Also serves as repeated start
   task automatic start();
      cond(1'b0, 1'b1);
      scl_out <= 1'b0;
      tick(4);
   endtask
   task automatic wbyte(input logic [7:0] d, inout logic ok);
      logic r;
      for (int i = 7; i >= 0; i--) xbit(d[i], r);
      xbit(1'b1, r);
      ok &= ~r;
   endtask
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) xbit(1'b1, d[i]);
      xbit(last, r);
   endtask
   // Reserved bits are the caller's business
   task automatic write_reg(input logic [4:0] p, input logic [7:0] d, output logic ok);
      ok = 1'b1;
      start();
      wbyte({DEV_ADDR, 1'b0}, ok);
      wbyte({1'b1, 2'h1, p}, ok);
      wbyte(d, ok);
      cond(1'b1, 1'b0);
   endtask
   // One auto-increment read, low byte first
   task automatic read_regs(input logic [4:0] p, input int n, output logic [15:0] d,
                            output logic ok);
      ok = 1'b1;
      d = 16'h0;
      start();
      wbyte({DEV_ADDR, 1'b0}, ok);
      wbyte({1'b1, 2'h1, p}, ok);
      start();
      wbyte({DEV_ADDR, 1'b1}, ok);
      rbyte(n == 1, d[7:0]);
      if (n == 2) rbyte(1'b1, d[15:8]);
      cond(1'b1, 1'b0);
   endtask
endmodule // pscsr_host_model
`default_nettype wire

//--- pscsr_regs_tb_top.sv
// Bench of the register bank: host on the serial pins.
// Assumes a 100 MHz clock; the wait step is shortened to STEP clocks.
`timescale 1ns/10ps
`default_nettype none
module pscsr_regs_tb_top
   import pscsr_pkg::*;
;
   localparam int STEP = 20;
   localparam logic [6:0] BUS_ADDR = 7'h2a; // Arbitrary value
   localparam logic [7:0] ID_CODE = 8'h5a; // Arbitrary value
   int checks = 0;
   int error_cnt = 0;
   logic mclk = 1'b0, srst = 1'b1, meas_en = 1'b0, wait_en = 1'b0;
   logic irq_en = 1'b0, irq_clr = 1'b0, res_vld = 1'b0;
   logic [7:0] wait_cnt = 8'hff;
   logic [15:0] low_thr = 16'h0100, high_thr = 16'h0200, res = 16'h0;
   wire logic scl, host_low, sda_line, sda_val, sda_oe, irq_oe, led, done, ch0, ch1;
   wire logic [3:0] drive;
   always #5 mclk = ~mclk;
   // Open-drain SDA with pull-up
   assign sda_line = ~(host_low | (sda_oe & ~sda_val));
   pscsr_regs #(.WAIT_STEP_CYC_P(STEP), .DEV_ADDR(BUS_ADDR), .PART_ID(ID_CODE)) uut (
      .mclk_in(mclk), .srst_in(srst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_val),
      .sda_oe_out(sda_oe), .irq_n_out(), .irq_oe_out(irq_oe), .meas_enable_in(meas_en),
      .wait_enable_in(wait_en), .wait_count_in(wait_cnt), .prox_irq_enable_in(irq_en),
      .prox_irq_clear_in(irq_clr), .low_thr_in(low_thr), .high_thr_in(high_thr),
      .result_in(res), .result_valid_in(res_vld), .led_pulse_out(led), .burst_done_out(done),
      .led_drive_scale_out(drive), .diode_ch0_en_out(ch0), .diode_ch1_en_out(ch1));
   pscsr_host_model #(.DEV_ADDR(BUS_ADDR)) host (.mclk_in(mclk), .sda_in(sda_line),
      .scl_out(scl), .sda_low_out(host_low));
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [4:0] p, input logic [7:0] v);
      logic ok;
      host.write_reg(p, v, ok);
   endtask
   // A refused transfer poisons the data
   task automatic rd(input logic [4:0] p, input int n, output logic [15:0] d);
      logic ok;
      host.read_regs(p, n, d, ok);
      if (ok !== 1'b1) d = 'x;
   endtask
   task automatic post(input logic [15:0] v);
      res <= v;
      res_vld <= 1'b1;
      @(posedge mclk);
      res_vld <= 1'b0;
      @(posedge mclk);
   endtask
   // Pulse count and delay to the first pulse, up to burst end
   task automatic burst(output int n, output int gap, output int per);
      int t0;
      logic prev;
      {prev, n, gap, per, t0} = '0;
      for (int t = 1; t < 20000; t++) begin
         @(posedge mclk);
         #1;
         if (led === 1'b1 && prev === 1'b0) begin
            if (n == 0) gap = t; else per = t - t0;
            t0 = t;
            n++;
         end
         prev = led;
         if (done === 1'b1) begin
            @(posedge mclk);
            return;
         end
      end
      error_cnt++;
      $display("unexpected burst end: expected done, seen none");
      results();
   endtask
   task automatic t_reset();
      logic [15:0] d;
      chk("drive scale", 16'h1, 16'(drive));
      rd(OFF_PART_ID, 1, d);
      chk("part id", 16'(ID_CODE), d);
      wr(OFF_PART_ID, 8'h00);
      rd(OFF_PART_ID, 1, d);
      chk("part id kept", 16'(ID_CODE), d);
      rd(OFF_FLAGS, 1, d);
      chk("flags idle", 16'h0, d);
      rd(5'h1f, 1, d);
      chk("unmapped", 16'h0, d);
      $display("test reset done");
   endtask
   // Reserved bits written as ones to see them dropped
   task automatic t_setup();
      logic [15:0] d;
      for (int i = 0; i < 16; i++) begin
         wr(OFF_SETUP, {i[3:0], 4'hf});
         rd(OFF_SETUP, 1, d);
         chk("setup", {8'h0, i[3:0], 4'h0}, d);
         chk("drive scale", 16'h1 << i[3:2], 16'(drive));
         chk("diodes", 16'(i[1:0]), 16'({ch1, ch0}));
      end
      wr(OFF_WAIT_EXT, 8'hff);
      rd(OFF_WAIT_EXT, 1, d);
      chk("wait ext", 16'h2, d);
      $display("test setup done");
   endtask
   task automatic t_result();
      logic [15:0] d;
      post(16'h1234);
      rd(OFF_RES_LO, 2, d);
      chk("result pair", 16'h1234, d);
      post(16'habcd);
      rd(OFF_RES_LO, 1, d);
      chk("result low", 16'h00cd, d);
      post(16'h5678);
      rd(OFF_RES_HI, 1, d);
      chk("shadow high", 16'h00ab, d);
      $display("test result done");
   endtask
   task automatic irq_case(input logic en, input logic [15:0] v, input logic exp);
      logic [15:0] d;
      irq_en <= en;
      post(v);
      chk("irq pin", 16'(exp), 16'(irq_oe));
      rd(OFF_FLAGS, 1, d);
      chk("irq flag", 16'(exp) << 5, d);
      irq_clr <= 1'b1;
      @(posedge mclk);
      irq_clr <= 1'b0;
      @(posedge mclk);
      chk("irq cleared", 16'h0, 16'(irq_oe));
   endtask
   task automatic t_irq();
      irq_case(1'b1, 16'h0300, 1'b1);
      irq_case(1'b1, 16'h0050, 1'b1);
      irq_case(1'b1, 16'h0100, 1'b0);
      irq_case(1'b1, 16'h0200, 1'b0);
      irq_case(1'b0, 16'h0300, 1'b0);
      irq_en <= 1'b0;
      $display("test irq done");
   endtask
   task automatic t_emit();
      int n, g0, g1, per;
      wr(OFF_WAIT_EXT, 8'h00);
      wr(OFF_PULSE, 8'h03);
      wait_cnt <= 8'hfe;
      wait_en <= 1'b1;
      meas_en <= 1'b1;
      burst(n, g0, per);
      chk("pulses", 16'd3, 16'(n));
      chk("pulse period", 16'd1600, 16'(per));
      burst(n, g0, per);
      meas_en <= 1'b0;
      wr(OFF_WAIT_EXT, 8'h02);
      meas_en <= 1'b1;
      burst(n, g1, per);
      burst(n, g1, per);
      meas_en <= 1'b0;
      chk("plain wait", 16'h1, 16'(g0 >= 2 * STEP - 2 && g0 <= 2 * STEP + 4));
      chk("stretch gain", 16'(11 * 2 * STEP), 16'(g1 - g0));
      $display("test emitter done");
   endtask
   task automatic results();
      $display("checks %0d, mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge mclk);
      srst <= 1'b0;
      repeat (6) @(posedge mclk);
      t_reset();
      t_setup();
      t_result();
      t_irq();
      t_emit();
      results();
   end
endmodule // pscsr_regs_tb_top
`default_nettype wire
